/* File: hdl/gsf_flags_regs.svh */
// Offsets, bit positions, reset values and sizes for the status flag register bank.
`ifndef GSF_FLAGS_REGS_SVH
`define GSF_FLAGS_REGS_SVH

`define GSF_ADDR_W          12
`define GSF_OFS_DIRECT      12'h00c
`define GSF_OFS_CLEAR       12'h010
`define GSF_OFS_SET         12'h014
`define GSF_OFS_HWCLR       12'h018
`define GSF_OFS_CTRL        12'h01c
`define GSF_OFS_OUT_LOW     12'h020
`define GSF_OFS_OUT_HIGH    12'h024
`define GSF_OFS_IN_LOW      12'h028
`define GSF_OFS_IN_HIGH     12'h02c

`define GSF_BIT_AU_RDY      25
`define GSF_BIT_PE_RDY      24
`define GSF_BIT_DEPTH       23
`define GSF_BIT_CMDW        22
`define GSF_BIT_EXT_IRQ     21
`define GSF_BIT_DRAM_TO     20
`define GSF_BIT_SYNC        19
`define GSF_BIT_BW          18
`define GSF_BIT_OVF         17
`define GSF_BIT_BADOP       16
`define GSF_BIT_EMPTY_RD    15
`define GSF_BIT_DPA_BUSY    12
`define GSF_BIT_IPA_BUSY    11
`define GSF_BIT_CPY_BUSY    10
`define GSF_BIT_AU_BUSY     9
`define GSF_BIT_PE_BUSY     8
`define GSF_BIT_OQ_LOW      7
`define GSF_BIT_OQ_HIGH     6
`define GSF_BIT_OQ_EMPTY    5
`define GSF_BIT_OQ_FULL     4
`define GSF_BIT_IQ_LOW      3
`define GSF_BIT_IQ_HIGH     2
`define GSF_BIT_IQ_EMPTY    1
`define GSF_BIT_IQ_FULL     0
`define GSF_BIT_CTRL_IRQEN  0

`define GSF_IMPL_MASK       32'h03ff9fff
`define GSF_FLAGS_RST       32'h00000000
`define GSF_HWCLR_RST       32'h00400000
`define GSF_CTRL_RST        32'h00000000
`define GSF_OUT_LOW_RST     8'h04
`define GSF_OUT_HIGH_RST    8'h1c
`define GSF_IN_LOW_RST      8'h04
`define GSF_IN_HIGH_RST     8'h1c
`define GSF_LVL_W           8
`define GSF_CODE_W          8
`define GSF_IDLE_CODE       8'h00
`define GSF_NS_PER_US       1000

`endif

/* File: hdl/gsf_flags_pkg.sv */
// Types shared by the status flag register bank.
package gsf_flags_pkg;
`include "gsf_flags_regs.svh"

	typedef enum logic [1:0] {
		GSF_MEM_INIT = 2'b00,
		GSF_MEM_RUN  = 2'b01
	} gsf_mem_state_t;

	typedef struct packed {
		logic                   psel;
		logic                   penable;
		logic                   pwrite;
		logic [`GSF_ADDR_W-1:0] paddr;
		logic [31:0]            pwdata;
		logic [3:0]             pstrb;
	} gsf_apb_req_t;

	typedef struct packed {
		logic access_unit_ready;
		logic pixel_engine_ready;
		logic direct_access_busy;
		logic indirect_access_busy;
		logic copy_unit_busy;
		logic access_unit_busy;
		logic pixel_engine_busy;
	} gsf_unit_stat_t;

	typedef struct packed {
		logic [31:0]           flags;
		logic [31:0]           hwclr;
		logic [31:0]           ctrl;
		logic [`GSF_LVL_W-1:0] out_low;
		logic [`GSF_LVL_W-1:0] out_high;
		logic [`GSF_LVL_W-1:0] in_low;
		logic [`GSF_LVL_W-1:0] in_high;
		logic [31:0]           prdata;
		logic                  pslverr;
		logic [2:0]            ext_sync;
		logic                  ext_level;
		gsf_mem_state_t        mem_state;
		logic [31:0]           init_cnt;
		logic [`GSF_CODE_W-1:0] exec_code;
		logic                  exec_stb;
		logic                  drain_only;
	} gsf_state_t;
endpackage : gsf_flags_pkg

/* File: hdl/gsf_flags.sv */
// Status flag register bank with APB slave, per-bit hardware-clear and flag sources.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps

module gsf_flags
	import gsf_flags_pkg::*;
#(
	parameter int unsigned            CLK_MHZ          = 40,
	parameter int unsigned            INIT_TIME_NS     = 200000,
	parameter int unsigned            INIT_CYCLES      = (INIT_TIME_NS * CLK_MHZ
	                                                     + `GSF_NS_PER_US - 1) / `GSF_NS_PER_US,
	parameter int unsigned            OUT_DEPTH        = 32,
	parameter int unsigned            IN_DEPTH         = 32,
	parameter logic [`GSF_CODE_W-1:0] NUM_CMD_CODES    = 8'h20,
	parameter bit                     HAS_EMPTY_READ   = 1'b1
) (
	input  wire logic                   clk,              // 40 MHz system clock
	input  wire logic                   reset_n,          // Asynchronous reset, active low
	input  wire gsf_apb_req_t           apb_req,          // APB request bundle
	output logic [31:0]                 prdata,           // APB read data
	output logic                        pready,           // APB ready
	output logic                        pslverr,          // APB error on unmapped address
	input  wire gsf_unit_stat_t         unit_stat,        // Ready and busy levels of units
	input  wire logic                   cmd_reg_free,     // Command register may take a command
	input  wire logic                   cmd_write,        // Pulse: command written
	input  wire logic [`GSF_CODE_W-1:0] cmd_code,         // Code of the written command
	output logic [`GSF_CODE_W-1:0]      exec_code,        // Code handed to execution
	output logic                        exec_stb,         // Pulse: exec_code is new
	input  wire logic                   copy_start,       // Pulse: copy command starts
	input  wire logic [3:0]             copy_src_depth,   // Source layer colour depth
	input  wire logic [3:0]             copy_dst_depth,   // Target layer colour depth
	output logic                        copy_drain_only,  // Copy unit must only drain input
	input  wire logic                   ext_irq_pin,      // External interrupt, asynchronous
	input  wire logic                   refresh_forced,   // Pulse: forced memory refresh
	input  wire logic                   sync_mixer_out,   // Display sync mixer output level
	input  wire logic                   bandwidth_fault,  // Pulse: display data came too late
	input  wire logic                   empty_read,       // Pulse: read from empty input queue
	input  wire logic [`GSF_LVL_W-1:0]  out_level,        // Output queue fill level
	input  wire logic [`GSF_LVL_W-1:0]  in_level,         // Input queue fill level
	output logic                        cmd_irq,          // Command-writable interrupt level
	output logic [31:0]                 flags_out         // Current flag register
);

	localparam logic [`GSF_LVL_W-1:0] OUT_FULL  = `GSF_LVL_W'(OUT_DEPTH);
	localparam logic [`GSF_LVL_W-1:0] IN_FULL   = `GSF_LVL_W'(IN_DEPTH);
	localparam logic [31:0]           INIT_LAST = 32'(INIT_CYCLES - 1);

	gsf_state_t st_reg;
	gsf_state_t st_next;

	logic [31:0] src;
	logic [31:0] lane_mask;
	logic [31:0] wdata_m;
	logic [31:0] sw_set;
	logic [31:0] sw_clr;
	logic [31:0] base;
	logic        setup;
	logic        access;
	logic        mapped;
	logic        ext_event;
	logic        init_event;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lane_mask[i*8 +: 8] = {8{apb_req.pstrb[i]}};
		end
	end

	always_comb begin
		st_next    = st_reg;
		src        = '0;
		sw_set     = '0;
		sw_clr     = '0;
		base       = '0;
		ext_event  = 1'b0;
		init_event = 1'b0;
		setup      = apb_req.psel & ~apb_req.penable;
		access     = apb_req.psel & apb_req.penable;
		wdata_m    = apb_req.pwdata & lane_mask;
		st_next.exec_stb = 1'b0;

		// Three-stage synchroniser; only agreeing late stages move the level.
		st_next.ext_sync = {st_reg.ext_sync[1:0], ext_irq_pin};
		if (st_reg.ext_sync[1] == st_reg.ext_sync[2]) begin
			st_next.ext_level = st_reg.ext_sync[2];
		end
		ext_event = st_next.ext_level & ~st_reg.ext_level;

		// Memory initialisation timer, then forced refresh reports.
		case (st_reg.mem_state)
			GSF_MEM_INIT: begin
				if (st_reg.init_cnt >= INIT_LAST) begin
					st_next.mem_state = GSF_MEM_RUN;
					init_event        = 1'b1;
				end else begin
					st_next.init_cnt = st_reg.init_cnt + 32'h00000001;
				end
			end
			GSF_MEM_RUN: begin
				init_event = refresh_forced;
			end
			default: begin
				st_next.mem_state = GSF_MEM_INIT;
				st_next.init_cnt  = '0;
			end
		endcase

		// Command screening: undefined codes run as the idle command.
		if (cmd_write) begin
			st_next.exec_stb = 1'b1;
			if (cmd_code >= NUM_CMD_CODES) begin
				st_next.exec_code = `GSF_IDLE_CODE;
			end else begin
				st_next.exec_code = cmd_code;
			end
		end

		// A mismatched copy only drains its input until the copy unit goes idle.
		if (copy_start && (copy_src_depth != copy_dst_depth)) begin
			st_next.drain_only = 1'b1;
		end else if (!unit_stat.copy_unit_busy && !copy_start) begin
			st_next.drain_only = 1'b0;
		end

		src[`GSF_BIT_AU_RDY]   = unit_stat.access_unit_ready;
		src[`GSF_BIT_PE_RDY]   = unit_stat.pixel_engine_ready;
		src[`GSF_BIT_DEPTH]    = copy_start & (copy_src_depth != copy_dst_depth);
		src[`GSF_BIT_CMDW]     = cmd_reg_free;
		src[`GSF_BIT_EXT_IRQ]  = ext_event;
		src[`GSF_BIT_DRAM_TO]  = init_event;
		src[`GSF_BIT_SYNC]     = sync_mixer_out;
		src[`GSF_BIT_BW]       = bandwidth_fault;
		src[`GSF_BIT_OVF]      = cmd_write & ~cmd_reg_free;
		src[`GSF_BIT_BADOP]    = cmd_write & (cmd_code >= NUM_CMD_CODES);
		src[`GSF_BIT_EMPTY_RD] = HAS_EMPTY_READ & empty_read;
		src[`GSF_BIT_DPA_BUSY] = unit_stat.direct_access_busy;
		src[`GSF_BIT_IPA_BUSY] = unit_stat.indirect_access_busy;
		src[`GSF_BIT_CPY_BUSY] = unit_stat.copy_unit_busy;
		src[`GSF_BIT_AU_BUSY]  = unit_stat.access_unit_busy;
		src[`GSF_BIT_PE_BUSY]  = unit_stat.pixel_engine_busy;
		src[`GSF_BIT_OQ_LOW]   = out_level <= st_reg.out_low;
		src[`GSF_BIT_OQ_HIGH]  = out_level >= st_reg.out_high;
		src[`GSF_BIT_OQ_EMPTY] = out_level == '0;
		src[`GSF_BIT_OQ_FULL]  = out_level >= OUT_FULL;
		src[`GSF_BIT_IQ_LOW]   = in_level <= st_reg.in_low;
		src[`GSF_BIT_IQ_HIGH]  = in_level >= st_reg.in_high;
		src[`GSF_BIT_IQ_EMPTY] = in_level == '0;
		src[`GSF_BIT_IQ_FULL]  = in_level >= IN_FULL;

		mapped = 1'b1;
		case (apb_req.paddr)
			`GSF_OFS_DIRECT, `GSF_OFS_CLEAR, `GSF_OFS_SET, `GSF_OFS_HWCLR,
			`GSF_OFS_CTRL, `GSF_OFS_OUT_LOW, `GSF_OFS_OUT_HIGH,
			`GSF_OFS_IN_LOW, `GSF_OFS_IN_HIGH: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase

		// Read data and error are captured in the setup cycle and shown in access.
		if (setup) begin
			st_next.pslverr = ~mapped;
			case (apb_req.paddr)
				`GSF_OFS_DIRECT, `GSF_OFS_CLEAR, `GSF_OFS_SET: begin
					st_next.prdata = st_reg.flags;
				end
				`GSF_OFS_HWCLR:    st_next.prdata = st_reg.hwclr;
				`GSF_OFS_CTRL:     st_next.prdata = st_reg.ctrl;
				`GSF_OFS_OUT_LOW:  st_next.prdata = 32'(st_reg.out_low);
				`GSF_OFS_OUT_HIGH: st_next.prdata = 32'(st_reg.out_high);
				`GSF_OFS_IN_LOW:   st_next.prdata = 32'(st_reg.in_low);
				`GSF_OFS_IN_HIGH:  st_next.prdata = 32'(st_reg.in_high);
				default:           st_next.prdata = '0;
			endcase
		end

		if (access && apb_req.pwrite && mapped) begin
			case (apb_req.paddr)
				`GSF_OFS_DIRECT: begin
					sw_set = wdata_m;
					sw_clr = ~apb_req.pwdata & lane_mask;
				end
				`GSF_OFS_CLEAR: sw_clr = wdata_m;
				`GSF_OFS_SET:   sw_set = wdata_m;
				`GSF_OFS_HWCLR: begin
					st_next.hwclr = ((st_reg.hwclr & ~lane_mask) | wdata_m)
					                & `GSF_IMPL_MASK;
				end
				`GSF_OFS_CTRL: begin
					st_next.ctrl[`GSF_BIT_CTRL_IRQEN] = apb_req.pstrb[0]
						? apb_req.pwdata[`GSF_BIT_CTRL_IRQEN]
						: st_reg.ctrl[`GSF_BIT_CTRL_IRQEN];
				end
				`GSF_OFS_OUT_LOW: begin
					if (apb_req.pstrb[0]) st_next.out_low = apb_req.pwdata[`GSF_LVL_W-1:0];
				end
				`GSF_OFS_OUT_HIGH: begin
					if (apb_req.pstrb[0]) st_next.out_high = apb_req.pwdata[`GSF_LVL_W-1:0];
				end
				`GSF_OFS_IN_LOW: begin
					if (apb_req.pstrb[0]) st_next.in_low = apb_req.pwdata[`GSF_LVL_W-1:0];
				end
				`GSF_OFS_IN_HIGH: begin
					if (apb_req.pstrb[0]) st_next.in_high = apb_req.pwdata[`GSF_LVL_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Dynamic bits drop their old value; hardware sources win over software clears.
		base = st_reg.flags & ~st_reg.hwclr;
		base = (base & ~sw_clr) | sw_set;
		st_next.flags = (base | src) & `GSF_IMPL_MASK;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg.flags      <= `GSF_FLAGS_RST;
			st_reg.hwclr      <= `GSF_HWCLR_RST;
			st_reg.ctrl       <= `GSF_CTRL_RST;
			st_reg.out_low    <= `GSF_OUT_LOW_RST;
			st_reg.out_high   <= `GSF_OUT_HIGH_RST;
			st_reg.in_low     <= `GSF_IN_LOW_RST;
			st_reg.in_high    <= `GSF_IN_HIGH_RST;
			st_reg.prdata     <= '0;
			st_reg.pslverr    <= 1'b0;
			st_reg.ext_sync   <= '0;
			st_reg.ext_level  <= 1'b0;
			st_reg.mem_state  <= GSF_MEM_INIT;
			st_reg.init_cnt   <= '0;
			st_reg.exec_code  <= `GSF_IDLE_CODE;
			st_reg.exec_stb   <= 1'b0;
			st_reg.drain_only <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pready          = 1'b1;
	assign prdata          = st_reg.prdata;
	assign pslverr         = st_reg.pslverr & apb_req.psel & apb_req.penable;
	assign exec_code       = st_reg.exec_code;
	assign exec_stb        = st_reg.exec_stb;
	assign copy_drain_only = st_reg.drain_only;
	assign cmd_irq         = st_reg.ctrl[`GSF_BIT_CTRL_IRQEN] & st_reg.flags[`GSF_BIT_CMDW];
	assign flags_out       = st_reg.flags;

endmodule : gsf_flags

/* File: testbench/gsf_flags_monitor.sv */
// Concurrent checks on the ports of the status flag register bank.
`timescale 1ns/1ps
module gsf_flags_monitor
	import gsf_flags_pkg::*;
(
	input wire logic           clk,             // Clock
	input wire logic           reset_n,         // Reset, active low
	input wire gsf_apb_req_t   apb_req,         // APB request
	input wire logic [31:0]    prdata,          // Read data
	input wire gsf_unit_stat_t unit_stat,       // Unit levels
	input wire logic           cmd_reg_free,    // Command register free
	input wire logic           cmd_write,       // Command strobe
	input wire logic [7:0]     cmd_code,        // Command code
	input wire logic [7:0]     exec_code,       // Executed code
	input wire logic           exec_stb,        // Execute strobe
	input wire logic           copy_start,      // Copy start
	input wire logic [3:0]     copy_src_depth,  // Source depth
	input wire logic [3:0]     copy_dst_depth,  // Target depth
	input wire logic           copy_drain_only, // Drain only
	input wire logic           ext_irq_pin,     // External interrupt
	input wire logic           cmd_irq,         // Command interrupt
	input wire logic [31:0]    flags_out        // Flags
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
	wire bad_copy = copy_start && copy_src_depth != copy_dst_depth && unit_stat[2];
	wire [7:0] want_code = cmd_code >= 8'h20 ? 8'h00 : cmd_code;

	reserved_zero_a: assert property (flags_out[31:26] == 6'h0 && flags_out[14:13] == 2'h0)
		else $error("reserved flag bits not zero");
	unit_ready_a: assert property (unit_stat[6] |-> ##[1:2] flags_out[25])
		else $error("ready flag missing");
	exec_code_a: assert property (cmd_write |=> exec_stb && exec_code == $past(want_code))
		else $error("executed code wrong");
	bad_opcode_a: assert property (cmd_write && cmd_code >= 8'h20 |-> ##[1:2] flags_out[16])
		else $error("bad opcode flag missing");
	overflow_set_a: assert property (cmd_write && !cmd_reg_free |-> ##[1:2] flags_out[17])
		else $error("overflow flag missing");
	writable_low_a: assert property (!cmd_reg_free [*2] |-> !flags_out[22])
		else $error("writable flag high while busy");
	cmd_irq_a: assert property (cmd_irq |-> flags_out[22])
		else $error("interrupt without writable flag");
	drain_only_a: assert property (bad_copy |=> copy_drain_only ##[0:1] flags_out[23])
		else $error("depth mismatch not flagged");
	ext_irq_a: assert property ($rose(ext_irq_pin) |-> ##[3:6] flags_out[21])
		else $error("external interrupt flag missing");
	read_flags_a: assert property (rd_acc && apb_req.paddr inside {12'h00c, 12'h010, 12'h014}
		|-> prdata == $past(flags_out))
		else $error("flag read data wrong");
	cover property (cmd_write && cmd_code >= 8'h20);
	cover property (copy_drain_only);
	cover property (cmd_irq);
endmodule : gsf_flags_monitor

/* File: testbench/gsf_host_model.sv */
// Host side: APB master and a command writer that polls the writable flag.
`timescale 1ns/1ps
module gsf_host_model
	import gsf_flags_pkg::*;
(
	input wire logic        clk,       // Clock
	output gsf_apb_req_t    apb_req,   // APB request
	input wire logic [31:0] prdata,    // Read data
	input wire logic        pready,    // Ready
	input wire logic        pslverr,   // Error
	output logic            cmd_write, // Command strobe
	output logic [7:0]      cmd_code   // Command code
);
	initial begin
		apb_req = '0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
	end
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		apb_req <= '{1'b1, 1'b0, w, a, d, 4'hf};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		apb_req <= '0;
	endtask : xfer
	task automatic command(input logic [7:0] c, input logic poll);
		logic [31:0] f;
		logic        e;
		f = 32'h0;
		while (f[22] !== 1'b1 && poll) xfer(1'b0, 12'h00c, 32'h0, f, e);
		@(posedge clk);
		cmd_write <= 1'b1;
		cmd_code <= c;
		@(posedge clk);
		cmd_write <= 1'b0;
	endtask : command
endmodule : gsf_host_model

/* File: testbench/tb_graphics_status_flag_register.sv */
// Self-checking bench for the status flag register bank.
`timescale 1ns/1ps
module tb_graphics_status_flag_register;
	import gsf_flags_pkg::*;
	localparam logic [31:0] CW  = 32'h00400000;
	localparam logic [31:0] SWM = 32'h03bf9fff;
	gsf_apb_req_t   apb_req;
	gsf_unit_stat_t unit_stat;
	logic           clk, reset_n, pready, pslverr, cmd_reg_free, cmd_write, exec_stb, cmd_irq;
	logic           copy_start, copy_drain_only, ext_irq_pin, refresh_forced, sync_mixer_out;
	logic           bandwidth_fault, empty_read, rd_err;
	logic [3:0]     copy_src_depth, copy_dst_depth;
	logic [7:0]     cmd_code, exec_code, out_level, in_level;
	logic [31:0]    prdata, flags_out, rd_data, mdl, rnd;
	int             err_total, checked, cyc;
	logic [11:0]    ra[9] = '{12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h020, 12'h024,
		12'h028, 12'h02c};
	logic [31:0]    rv[9] = '{32'h00500000, 32'h00500000, 32'h00500000, CW, 0, 4, 28, 4, 28};
	logic [31:0]    ex[20] = '{32'h02000000, 32'h01000000, 32'h1000, 32'h800, 32'h400, 32'h200,
		32'h100, 32'h00200000, 32'h00100000, 32'h00080000, 32'h00040000, 32'h8000,
		32'h80, 32'h40, 32'ha0, 32'h50, 32'h08, 32'h04, 32'h0a, 32'h05};
	logic [7:0]     lv[4] = '{8'h04, 8'h1c, 8'h00, 8'h20};
	logic [7:0]     codes[4] = '{8'h00, 8'h1f, 8'h20, 8'hff};

	gsf_flags #(.INIT_CYCLES(10)) gsf_flags_inst (.clk, .reset_n, .apb_req, .prdata, .pready,
		.pslverr, .unit_stat, .cmd_reg_free, .cmd_write, .cmd_code, .exec_code, .exec_stb,
		.copy_start, .copy_src_depth, .copy_dst_depth, .copy_drain_only, .ext_irq_pin,
		.refresh_forced, .sync_mixer_out, .bandwidth_fault, .empty_read, .out_level,
		.in_level, .cmd_irq, .flags_out);
	gsf_host_model gsf_host_model_inst (.clk, .apb_req, .prdata, .pready, .pslverr,
		.cmd_write, .cmd_code);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		gsf_host_model_inst.xfer(1'b0, a, 32'h0, rd_data, rd_err);
		chk(rd_data, exp);
	endtask : rd
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		gsf_host_model_inst.xfer(1'b1, a, d, rd_data, rd_err);
	endtask : wr
	// Sources 0 to 6 are unit levels, 7 to 11 single events, then queue levels.
	task automatic put(input int k, input logic on);
		if (k < 7)
			unit_stat[6-k] <= on;
		else if (k < 12)
			{ext_irq_pin, refresh_forced, sync_mixer_out, bandwidth_fault, empty_read}
				<= on ? 5'(5'h10 >> (k - 7)) : 5'h0;
		else if (k < 16)
			out_level <= on ? lv[k-12] : 8'h10;
		else
			in_level <= on ? lv[k-16] : 8'h10;
	endtask : put
	task automatic finish_test();
		$display("errors=%0d checks=%0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end
	initial begin
		reset_n = 1'b0;
		unit_stat = '0;
		cmd_reg_free = 1'b1;
		{copy_start, ext_irq_pin, refresh_forced, sync_mixer_out, bandwidth_fault} = '0;
		empty_read = 1'b0;
		{copy_src_depth, copy_dst_depth} = 8'h00;
		out_level = 8'h10;
		in_level = 8'h10;
		void'($urandom(32'h9bed29f5));
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (12) @(posedge clk);
		for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
		gsf_host_model_inst.xfer(1'b0, 12'h100, 32'h0, rd_data, rd_err);
		chk({rd_data[30:0], rd_err}, 32'h1);
		mdl = 32'h0;
		for (int i = 0; i < 6; i++) begin
			rnd = $urandom() & ~CW;
			wr(12'h00c + 12'(4 * (i % 3)), rnd);
			mdl = SWM & ((i % 3 == 0) ? rnd : (i % 3 == 1) ? mdl & ~rnd : mdl | rnd);
			rd(12'h00c + 12'(4 * (i % 3)), mdl | CW);
		end
		for (int k = 0; k < 20; k++) begin
			wr(12'h010, 32'hffffffff);
			put(k, 1'b1);
			repeat (6) @(posedge clk);
			put(k, 1'b0);
			rd(12'h00c, ex[k] | CW);
		end
		for (int i = 0; i < 4; i++) begin
			wr(12'h010, 32'hffffffff);
			gsf_host_model_inst.command(codes[i], 1'b1);
			@(negedge clk);
			chk({23'h0, exec_stb, exec_code}, {24'h1, codes[i] < 8'h20 ? codes[i] : 8'h00});
			rd(12'h00c, (codes[i] < 8'h20 ? 32'h0 : 32'h00010000) | CW);
		end
		wr(12'h010, 32'hffffffff);
		cmd_reg_free <= 1'b0;
		gsf_host_model_inst.command(8'h01, 1'b0);
		rd(12'h00c, 32'h00020000);
		cmd_reg_free <= 1'b1;
		wr(12'h01c, 32'h1);
		repeat (2) @(negedge clk);
		chk({31'h0, cmd_irq}, 32'h1);
		@(posedge clk);
		cmd_reg_free <= 1'b0;
		repeat (3) @(negedge clk);
		chk({31'h0, cmd_irq}, 32'h0);
		@(posedge clk);
		cmd_reg_free <= 1'b1;
		unit_stat[2] <= 1'b1;
		{copy_start, copy_src_depth, copy_dst_depth} <= 9'h148;
		@(posedge clk);
		copy_start <= 1'b0;
		@(negedge clk);
		chk({31'h0, copy_drain_only}, 32'h1);
		rd(12'h00c, 32'h00820400 | CW);
		unit_stat[2] <= 1'b0;
		wr(12'h010, 32'hffffffff);
		chk({31'h0, copy_drain_only}, 32'h0);
		wr(12'h018, CW | 32'h8);
		in_level <= 8'h04;
		rd(12'h00c, CW | 32'h8);
		in_level <= 8'h10;
		rd(12'h00c, CW);
		finish_test();
	end
endmodule : tb_graphics_status_flag_register

bind gsf_flags gsf_flags_monitor gsf_flags_monitor_inst (.clk, .reset_n, .apb_req, .prdata,
	.unit_stat, .cmd_reg_free, .cmd_write, .cmd_code, .exec_code, .exec_stb, .copy_start,
	.copy_src_depth, .copy_dst_depth, .copy_drain_only, .ext_irq_pin, .cmd_irq, .flags_out);
